// [sfl_cfg.svh]
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

// register word offsets (byte addresses, one 32-bit word each)
`define SFL_ADDR_STATUS 5'h00
`define SFL_ADDR_DATA 5'h04
`define SFL_ADDR_CTRL1 5'h08
`define SFL_ADDR_CTRL3 5'h0C
`define SFL_ADDR_INTEN 5'h10
`define SFL_ADDR_EVENT 5'h14

// status, interrupt enable and event layout
`define SFL_BIT_TX_EMPTY 7
`define SFL_BIT_TX_DONE 6
`define SFL_BIT_RX_FULL 5
`define SFL_BIT_IDLE 4
`define SFL_BIT_OVERRUN 3
`define SFL_BIT_NOISE 2
`define SFL_BIT_FRAMING 1
`define SFL_BIT_PARITY 0

// serial_control_one fields
`define SFL_C1_TX_EN 0
`define SFL_C1_RX_EN 1
`define SFL_C1_NINE 2
`define SFL_C1_LOOP 3
`define SFL_C1_RECEIVER_SOURCE_SELECT 4
`define SFL_C1_PAR_EN 5
`define SFL_C1_PAR_ODD 6

// serial_control_three fields
`define SFL_C3_TX_NINTH 0
`define SFL_C3_RX_NINTH 1
`define SFL_C3_TX_DIR 2

// reset values
`define SFL_RST_CTRL1 8'h00
`define SFL_RST_CTRL3 8'h00
`define SFL_RST_INTEN 8'h00

// timing: bus clocks per bit, frame lengths in bit times
`define SFL_CLKS_PER_BIT 16
`define SFL_FRAME_BITS8 4'hA
`define SFL_FRAME_BITS9 4'hB

`endif

// [sfl_pkg.sv]
`default_nettype none

package sfl_pkg;
    typedef logic [31:0] sfl_word_t;
    typedef logic [7:0] sfl_byte_t;
    typedef logic [8:0] sfl_char_t;

    // receiver frame states, one-hot
    typedef enum logic [3:0] {
        SFL_RX_IDLE = 4'b0001,
        SFL_RX_START = 4'b0010,
        SFL_RX_DATA = 4'b0100,
        SFL_RX_STOP = 4'b1000
    } sfl_rx_state_e;
endpackage

`default_nettype wire

// [sfl_tx_shifter.sv]
`include "sfl_cfg.svh"
`default_nettype none

module sfl_tx_shifter #(
    parameter int CLKS_PER_BIT = `SFL_CLKS_PER_BIT
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic load,
    input wire sfl_pkg::sfl_char_t data,
    input wire logic nine,
    output logic line,
    output logic busy
);
    import sfl_pkg::*;

    localparam int CW = $clog2(CLKS_PER_BIT + 1);
    localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);

    if (CLKS_PER_BIT < 4) begin : g_bad_rate
        $error("sfl_tx_shifter: CLKS_PER_BIT must be at least 4");
    end

    logic [9:0] sh_q;
    logic [3:0] left_q;
    logic [CW-1:0] cnt_q;
    logic line_q;
    logic busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // frame: start 0, data lsb first, optional ninth bit, stop 1
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sh_q <= 10'h3FF;
            left_q <= 4'h0;
            cnt_q <= '0;
            line_q <= 1'b1;
            busy_q <= 1'b0;
        end else if (run) begin
            if (load && !busy_q) begin
                // ninth bit is taken in the same transfer as the byte
                sh_q <= nine ? {1'b1, data} : {2'b11, data[7:0]};
                left_q <= nine ? (`SFL_FRAME_BITS9 - 4'h1) : (`SFL_FRAME_BITS8 - 4'h1);
                cnt_q <= '0;
                line_q <= 1'b0;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == LAST) begin
                    cnt_q <= '0;
                    if (left_q == 4'h0) begin
                        busy_q <= 1'b0; // stop bit done, line stays high
                    end else begin
                        line_q <= sh_q[0];
                        sh_q <= {1'b1, sh_q[9:1]};
                        left_q <= left_q - 4'h1;
                    end
                end else begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    end

    assign line = line_q;
    assign busy = busy_q;
endmodule // sfl_tx_shifter

`default_nettype wire

// [sfl_sci_flags.sv]
// Implementation choices: the Avalon-MM register port and the register addresses.
`include "sfl_cfg.svh"
`default_nettype none

module sfl_sci_flags #(
    parameter int CLKS_PER_BIT = `SFL_CLKS_PER_BIT
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic stop_req,
    input wire logic stop_deep,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire sfl_pkg::sfl_word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output sfl_pkg::sfl_word_t avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_tx_pin_i,
    output logic serial_tx_pin_o,
    output logic serial_tx_pin_oe,
    input wire logic serial_rx_pin_i,
    output logic serial_rx_pin_gpio,
    output logic irq_tx,
    output logic irq_rx,
    output logic irq_err,
    output logic irq
);
    import sfl_pkg::*;

    localparam int CW = $clog2(11 * CLKS_PER_BIT + 1);
    localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);
    localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2);

    if (CLKS_PER_BIT < 4) begin : g_bad_rate
        $error("sfl_sci_flags: CLKS_PER_BIT must be at least 4");
    end

    // frame length in bit times for the selected data length
    function automatic logic [3:0] frame_len(input logic nine);
        return nine ? `SFL_FRAME_BITS9 : `SFL_FRAME_BITS8;
    endfunction

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        return a == r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // stop modes: clocks halt in all of them, deep ones wipe the registers
    logic run;
    logic rst_i;
    assign run = clk_en & ~stop_req;
    assign rst_i = sys_rst | (clk_en & stop_req & stop_deep);

    // pin synchronisers
    logic [1:0] txp_s;
    logic [1:0] rxp_s;
    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            txp_s <= 2'b11;
            rxp_s <= 2'b11;
        end else if (run) begin
            txp_s <= {txp_s[0], serial_tx_pin_i};
            rxp_s <= {rxp_s[0], serial_rx_pin_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: every access waits exactly one cycle, more while run is low
    logic ack_q;
    logic req;
    logic rd_done;
    logic wr_done;
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~(ack_q & run);
    assign rd_done = avs_read & ack_q & run;
    assign wr_done = avs_write & ack_q & run & avs_byteenable[0];

    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (run) begin
            ack_q <= req & ~ack_q;
        end
    end

    // control registers
    sfl_byte_t ctrl1_q;
    sfl_byte_t inten_q;
    logic tx_ninth_q;
    logic tx_pin_direction_q;
    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            ctrl1_q <= `SFL_RST_CTRL1;
            inten_q <= `SFL_RST_INTEN;
            tx_ninth_q <= 1'(`SFL_RST_CTRL3 >> `SFL_C3_TX_NINTH);
            tx_pin_direction_q <= 1'(`SFL_RST_CTRL3 >> `SFL_C3_TX_DIR);
        end else if (wr_done) begin
            if (hit(avs_address, `SFL_ADDR_CTRL1)) begin
                ctrl1_q <= avs_writedata[7:0];
            end
            if (hit(avs_address, `SFL_ADDR_INTEN)) begin
                inten_q <= avs_writedata[7:0];
            end
            if (hit(avs_address, `SFL_ADDR_CTRL3)) begin
                // kept apart from the data write so software sets it first
                tx_ninth_q <= avs_writedata[`SFL_C3_TX_NINTH];
                tx_pin_direction_q <= avs_writedata[`SFL_C3_TX_DIR];
            end
        end
    end

    logic tx_en, rx_en, nine, lp, receiver_source_select, sw;
    assign tx_en = ctrl1_q[`SFL_C1_TX_EN];
    assign rx_en = ctrl1_q[`SFL_C1_RX_EN];
    assign nine = ctrl1_q[`SFL_C1_NINE];
    assign lp = ctrl1_q[`SFL_C1_LOOP];
    assign receiver_source_select = ctrl1_q[`SFL_C1_RECEIVER_SOURCE_SELECT];
    assign sw = lp & receiver_source_select;

    ////////////////////////////////////////////////////////////////////////////
    // transmit buffer and shifter
    sfl_byte_t buf_q;
    logic buf_full_q;
    logic tc_q;
    logic tx_busy;
    logic tx_line;
    logic tx_load;
    logic dt_wr;
    logic tc_set;
    assign dt_wr = wr_done & hit(avs_address, `SFL_ADDR_DATA);
    assign tx_load = run & buf_full_q & ~tx_busy & tx_en;
    assign tc_set = ~tc_q & ~buf_full_q & ~tx_busy & ~dt_wr & run;

    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            buf_q <= 8'h00;
            buf_full_q <= 1'b0;
            tc_q <= 1'b1;
        end else if (run) begin
            if (dt_wr) begin
                buf_q <= avs_writedata[7:0];
                buf_full_q <= 1'b1;
            end else if (tx_load) begin
                buf_full_q <= 1'b0; // room again for a character
            end
            // complete only with nothing queued and shifter back at idle high
            if (dt_wr) begin
                tc_q <= 1'b0;
            end else if (tc_set) begin
                tc_q <= 1'b1;
            end
        end
    end

    sfl_tx_shifter #(
        .CLKS_PER_BIT(CLKS_PER_BIT)
    ) u_tx (
        .sys_clk(sys_clk),
        .sys_rst(rst_i),
        .run(run),
        .load(tx_load),
        .data({tx_ninth_q, buf_q}),
        .nine(nine),
        .line(tx_line),
        .busy(tx_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin routing and receiver source
    logic rx_src;
    always_comb begin
        if (!lp) begin
            rx_src = rxp_s[1];
        end else if (!receiver_source_select) begin
            rx_src = tx_line; // internal loop
        end else begin
            rx_src = tx_pin_direction_q ? tx_line : txp_s[1];
        end
    end
    assign serial_tx_pin_o = tx_line;
    assign serial_tx_pin_oe = sw ? tx_pin_direction_q : tx_en;
    assign serial_rx_pin_gpio = lp; // receive pin handed back

    ////////////////////////////////////////////////////////////////////////////
    // receiver: three samples around mid-bit, majority vote
    sfl_rx_state_e rx_st_q;
    logic [CW-1:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    sfl_char_t rx_sh_q;
    logic rx_noise_q;
    logic [2:0] rx_h_q;
    logic maj, noisy, samp, bit_end, rx_done;
    sfl_char_t rx_word;
    logic rx_fe_w, rx_pf_w, rx_nf_w;

    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            rx_h_q <= 3'b111;
        end else if (run) begin
            rx_h_q <= {rx_h_q[1:0], rx_src};
        end
    end

    assign maj = (rx_h_q[0] & rx_h_q[1]) | (rx_h_q[1] & rx_h_q[2]) | (rx_h_q[0] & rx_h_q[2]);
    assign noisy = ~(&rx_h_q) & (|rx_h_q);
    assign samp = rx_cnt_q == HALF;
    assign bit_end = rx_cnt_q == LAST;
    assign rx_done = run & rx_en & (rx_st_q == SFL_RX_STOP) & samp;
    assign rx_word = nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    assign rx_fe_w = ~maj; // stop bit must be 1
    assign rx_nf_w = rx_noise_q | noisy;
    assign rx_pf_w = ctrl1_q[`SFL_C1_PAR_EN] & ((^rx_word) != ctrl1_q[`SFL_C1_PAR_ODD]);

    // frame sequencer
    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            rx_st_q <= SFL_RX_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_noise_q <= 1'b0;
        end else if (run) begin
            rx_cnt_q <= (bit_end || rx_st_q == SFL_RX_IDLE) ? '0 : rx_cnt_q + CW'(1);
            case (rx_st_q)
                SFL_RX_IDLE: begin
                    rx_noise_q <= 1'b0;
                    if (rx_en && rx_h_q[1] && !rx_h_q[0]) begin
                        rx_st_q <= SFL_RX_START; // falling edge opens a frame
                        rx_cnt_q <= CW'(1);
                    end
                end
                SFL_RX_START: begin
                    if (samp) begin
                        rx_noise_q <= noisy;
                        if (maj) begin
                            rx_st_q <= SFL_RX_IDLE; // glitch, not a start bit
                        end
                    end else if (bit_end) begin
                        rx_st_q <= SFL_RX_DATA;
                        rx_bit_q <= 4'h0;
                    end
                end
                SFL_RX_DATA: begin
                    if (samp) begin
                        rx_sh_q <= {maj, rx_sh_q[8:1]}; // lsb first
                        rx_noise_q <= rx_noise_q | noisy;
                    end else if (bit_end) begin
                        if (rx_bit_q == frame_len(nine) - 4'h3) begin
                            rx_st_q <= SFL_RX_STOP;
                        end else begin
                            rx_bit_q <= rx_bit_q + 4'h1;
                        end
                    end
                end
                SFL_RX_STOP: begin
                    // leave at mid stop bit so a next start edge is seen at once
                    if (samp) begin
                        rx_st_q <= SFL_RX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= SFL_RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // idle line detection, one full frame of high after a character
    logic [CW-1:0] idle_cnt_q;
    logic idle_allow_q;
    logic idle_ev;
    assign idle_ev = run & rx_en & idle_allow_q & (rx_st_q == SFL_RX_IDLE) & rx_h_q[0]
        & (idle_cnt_q == CW'(int'(frame_len(nine)) * CLKS_PER_BIT - 1));

    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            idle_cnt_q <= '0;
        end else if (run) begin
            if (rx_st_q != SFL_RX_IDLE || !rx_h_q[0]) begin
                idle_cnt_q <= '0;
            end else if (!idle_ev && idle_allow_q) begin
                idle_cnt_q <= idle_cnt_q + CW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive flags and two-step clear
    logic rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q, pf_q, rx_ninth_q;
    sfl_byte_t rxd_q;
    sfl_byte_t rdata_q;
    logic [5:0] arm_q;
    logic [5:0] clr;
    logic st_rd, dt_rd, full_eff, rx_acc, rx_ovr;
    sfl_byte_t status;
    assign status = {~buf_full_q, tc_q, rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q, pf_q};
    assign st_rd = rd_done & hit(avs_address, `SFL_ADDR_STATUS);
    assign dt_rd = rd_done & hit(avs_address, `SFL_ADDR_DATA);
    assign clr = dt_rd ? arm_q : 6'h00;
    assign full_eff = rx_buffer_full_flag_q & ~clr[`SFL_BIT_RX_FULL]; // a clear in the same cycle makes room
    assign rx_acc = rx_done & ~full_eff;
    assign rx_ovr = rx_done & full_eff;

    // the value software saw on the status read is what arms the clear
    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            arm_q <= 6'h00;
        end else if (st_rd) begin
            arm_q <= rdata_q[5:0];
        end else if (dt_rd) begin
            arm_q <= 6'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            rx_buffer_full_flag_q <= 1'b0;
            idle_q <= 1'b0;
            or_q <= 1'b0;
            nf_q <= 1'b0;
            fe_q <= 1'b0;
            pf_q <= 1'b0;
            rxd_q <= 8'h00;
            rx_ninth_q <= 1'b0;
            idle_allow_q <= 1'b0;
        end else if (run) begin
            if (rx_acc) begin
                rx_buffer_full_flag_q <= 1'b1; // set wins over a clear
                rxd_q <= rx_word[7:0];
                rx_ninth_q <= rx_word[8];
                nf_q <= rx_nf_w; // errors land with receive full
                fe_q <= rx_fe_w;
                pf_q <= rx_pf_w;
            end else begin
                if (clr[`SFL_BIT_RX_FULL]) rx_buffer_full_flag_q <= 1'b0;
                if (clr[`SFL_BIT_NOISE]) nf_q <= 1'b0;
                if (clr[`SFL_BIT_FRAMING]) fe_q <= 1'b0;
                if (clr[`SFL_BIT_PARITY]) pf_q <= 1'b0;
            end
            // overrun keeps old data, new character and its errors dropped
            if (rx_ovr) begin
                or_q <= 1'b1;
            end else if (clr[`SFL_BIT_OVERRUN]) begin
                or_q <= 1'b0;
            end
            if (idle_ev) begin
                idle_q <= 1'b1;
            end else if (clr[`SFL_BIT_IDLE]) begin
                idle_q <= 1'b0;
            end
            // idle may fire once per received character
            if (rx_acc) begin
                idle_allow_q <= 1'b1;
            end else if (idle_ev) begin
                idle_allow_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky events, cleared by reading them; a new event beats the clear
    sfl_byte_t ev_q;
    sfl_byte_t ev_new;
    logic ev_rd;
    assign ev_new = {tx_load, tc_set, rx_acc, idle_ev, rx_ovr,
        rx_acc & rx_nf_w, rx_acc & rx_fe_w, rx_acc & rx_pf_w};
    assign ev_rd = rd_done & hit(avs_address, `SFL_ADDR_EVENT);

    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            ev_q <= 8'h00;
        end else if (run) begin
            ev_q <= (ev_q & ~(ev_rd ? rdata_q : 8'h00)) | ev_new;
        end
    end

    // read data captured on the first cycle of the access
    always_ff @(posedge sys_clk) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (run && req && !ack_q) begin
            case (avs_address)
                `SFL_ADDR_STATUS: rdata_q <= status; // flags readable even when masked
                `SFL_ADDR_DATA: rdata_q <= rxd_q;
                `SFL_ADDR_CTRL1: rdata_q <= ctrl1_q;
                `SFL_ADDR_CTRL3: rdata_q <= {5'h00, tx_pin_direction_q, rx_ninth_q, tx_ninth_q};
                `SFL_ADDR_INTEN: rdata_q <= inten_q;
                `SFL_ADDR_EVENT: rdata_q <= ev_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign avs_readdata = {24'h00_0000, rdata_q};

    ////////////////////////////////////////////////////////////////////////////
    // interrupt outputs: three grouped levels plus the sticky-event line
    assign irq_tx = (~buf_full_q & inten_q[`SFL_BIT_TX_EMPTY])
        | (tc_q & inten_q[`SFL_BIT_TX_DONE]);
    assign irq_rx = (rx_buffer_full_flag_q & inten_q[`SFL_BIT_RX_FULL])
        | (idle_q & inten_q[`SFL_BIT_IDLE]);
    assign irq_err = |(status[3:0] & inten_q[3:0]);
    assign irq = |(ev_q & inten_q);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst_i);

    tx_buffer_empty_flag_irq_a: assert property (!buf_full_q && inten_q[7] |-> irq_tx)
        else $error("transmit empty interrupt missing");
    tx_buffer_empty_flag_set_a: assert property (tx_load && !dt_wr |=> !buf_full_q ##1 !buf_full_q || $past(dt_wr))
        else $error("buffer not emptied on load");
    tc_idle_a: assert property (tc_q |-> !tx_busy && tx_line)
        else $error("complete flag with line busy");
    rx_buffer_full_flag_hold_a: assert property (run && rx_buffer_full_flag_q && !clr[5] |=> rx_buffer_full_flag_q)
        else $error("receive full dropped without sequence");
    rx_buffer_full_flag_clear_a: assert property (run && dt_rd && arm_q[5] && !rx_done |=> !rx_buffer_full_flag_q)
        else $error("receive full not cleared by data read");
    // idle and accept cannot share a cycle, so the next cycle must be disarmed
    idle_once_a: assert property (idle_ev |=> !idle_allow_q)
        else $error("idle rearm failed");
    idle_block_a: assert property (!idle_allow_q |-> !idle_ev)
        else $error("idle set without new character");
    err_with_full_a: assert property (rx_acc && rx_fe_w |=> fe_q && rx_buffer_full_flag_q)
        else $error("framing flag not set with receive full");
    overrun_keep_a: assert property (rx_ovr |=> or_q && $stable(rxd_q) && $stable(fe_q))
        else $error("overrun did not keep old data");
    loop_src_a: assert property (lp && !receiver_source_select |-> rx_src == tx_line && serial_rx_pin_gpio)
        else $error("loop mode routing wrong");
    single_dir_a: assert property (sw |-> serial_tx_pin_oe == tx_pin_direction_q)
        else $error("single-wire direction wrong");

    rx_ok_c: cover property (rx_acc);
    overrun_c: cover property (rx_ovr);
    idle_c: cover property (idle_ev);
    single_wire_c: cover property (sw && tx_pin_direction_q && tx_busy);
endmodule // sfl_sci_flags

`default_nettype wire

// [sfl_peer.sv]
`default_nettype none

module sfl_peer #(
    parameter int CPB = 4
) (
    input wire logic sys_clk,
    input wire logic tx_line,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] heard [$];
    logic [7:0] cap;
    initial rx_line = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // drive one 8-bit frame onto the receive line; idle level is mark
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (CPB) @(posedge sys_clk);
        end
    endtask
    // listen on the transmit wire, sampling mid-bit; start must read low
    // sampled on the falling edge, away from the edge that moves the line
    always begin
        @(negedge sys_clk);
        if (tx_line === 1'b0) begin
            repeat (CPB / 2) @(negedge sys_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (CPB) @(negedge sys_clk);
                cap[i] = tx_line;
            end
            repeat (CPB) @(negedge sys_clk);
            heard.push_back(cap);
        end
    end
endmodule // sfl_peer

`default_nettype wire

// [sci_flags_and_line_modes_test.sv]
`default_nettype none

module sci_flags_and_line_modes_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic [4:0] avs_address = 0;
    sfl_pkg::sfl_word_t avs_writedata = 0, avs_readdata;
    logic avs_waitrequest, tx_o, tx_oe, rx_line, rx_gpio, irq_tx, irq_rx, irq_err, irq;
    logic clk_en = 1, stop_req = 0, stop_deep = 0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [7:0] r, b, exp_q [$];
    // far end drives the shared wire when the block lets go; it idles high
    wire logic tx_wire = tx_oe ? tx_o : rx_line;
    int bad_count = 0, num_checks = 0, n;
    always #10 sys_clk = ~sys_clk;
    sfl_sci_flags #(.CLKS_PER_BIT(4)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .stop_req(stop_req), .stop_deep(stop_deep), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .serial_tx_pin_i(tx_wire), .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe),
        .serial_rx_pin_i(rx_line), .serial_rx_pin_gpio(rx_gpio), .irq_tx(irq_tx),
        .irq_rx(irq_rx), .irq_err(irq_err), .irq(irq));
    sfl_peer #(.CPB(4)) i_peer (.sys_clk(sys_clk), .tx_line(tx_wire), .rx_line(rx_line));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus cycle; request held until the edge where waitrequest is low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h00_0000, d};
        // look mid-cycle at the settled value the next rising edge will see
        do @(negedge sys_clk); while (avs_waitrequest !== 1'b0);
        @(posedge sys_clk);
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk); // spacer so no signal is driven twice in one step
    endtask
    // wait for a received character, then the status-then-data read that clears it
    task automatic get_rx;
        for (int i = 0; i < 300 && irq_rx !== 1'b1; i++) @(posedge sys_clk);
        bus(0, 5'h00, 0);
        bus(0, 5'h04, 0);
    endtask
    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(63));
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        bus(0, 5'h00, 0); chk("status reset", 8'hC0, r);
        bus(0, 5'h18, 0); chk("unmapped", 8'h00, r);
        bus(1, 5'h08, 8'h03);
        bus(1, 5'h10, 8'h28);
        chk("irq_tx masked", 0, irq_tx);
        bus(0, 5'h00, 0); chk("tx empty polled", 8'h80, r & 8'h80);
        // transmit a random byte and hear it at the far end
        b = 8'($urandom);
        bus(1, 5'h04, b);
        for (n = 0; n < 300 && i_peer.heard.size() == 0; n++) @(posedge sys_clk);
        chk("tx char", b, (i_peer.heard.size() > 0) ? i_peer.heard.pop_front() : ~b);
        // two characters unread: the second overruns and is lost
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            if (k == 0) exp_q.push_back(b);
            i_peer.send(b);
        end
        repeat (10) @(posedge sys_clk);
        chk("irq_rx", 1, irq_rx);
        chk("irq_err", 1, irq_err);
        chk("irq", 1, irq);
        bus(0, 5'h00, 0); chk("full+overrun", 8'h68, r & 8'h6F);
        bus(0, 5'h04, 0); chk("rx data", exp_q.pop_front(), r);
        bus(0, 5'h00, 0); chk("full cleared", 8'h00, r & 8'h20);
        // internal loop, nine-bit, ninth bit written before the data
        bus(1, 5'h0C, 8'h01);
        bus(1, 5'h08, 8'h0F);
        chk("rx released", 1, rx_gpio);
        b = 8'($urandom);
        bus(1, 5'h04, b);
        get_rx(); chk("loop data", b, r);
        bus(0, 5'h0C, 0); chk("rx ninth", 8'h02, r & 8'h02);
        // single-wire: direction bit alone decides who drives the pin
        bus(1, 5'h08, 8'h1B);
        bus(1, 5'h0C, 8'h04); chk("oe drive", 1, tx_oe);
        b = 8'($urandom);
        bus(1, 5'h04, b);
        get_rx(); chk("own char", b, r);
        bus(1, 5'h0C, 8'h00); chk("oe input", 0, tx_oe);
        b = 8'($urandom);
        i_peer.send(b);
        get_rx(); chk("wire char", b, r);
        // shallow stop freezes and keeps, deep stop wipes
        stop_req <= 1'b1;
        repeat (5) @(posedge sys_clk);
        stop_req <= 1'b0;
        bus(0, 5'h08, 0); chk("stop keeps", 8'h1B, r);
        stop_req <= 1'b1;
        stop_deep <= 1'b1;
        @(posedge sys_clk);
        stop_req <= 1'b0;
        stop_deep <= 1'b0;
        bus(0, 5'h08, 0); chk("deep stop wipes", 8'h00, r);
        // a write without the low byte lane enabled is ignored
        avs_byteenable <= 4'hE;
        bus(1, 5'h08, 8'h03);
        avs_byteenable <= 4'hF;
        bus(0, 5'h08, 0); chk("lane off", 8'h00, r);
        close_out();
    end
endmodule // sci_flags_and_line_modes_test

`default_nettype wire
